// ---- src/epe_defines.vh ----
// constants for the enhanced parallel port cycle engine
`ifndef EPE_DEFINES_VH
`define EPE_DEFINES_VH
`define EPE_OFS_ADDR 3'h3
`define EPE_OFS_DATA0 3'h4
`define EPE_OFS_DATA1 3'h5
`define EPE_OFS_DATA2 3'h6
`define EPE_OFS_DATA3 3'h7
`define EPE_BYTE_RESET 8'h00
`define EPE_TMO_BIT 0
`define EPE_CLK_MHZ 20
`define EPE_TMO_USEC 10
`define EPE_TMO_CYCLES (`EPE_TMO_USEC * `EPE_CLK_MHZ)
`define EPE_FIFO_DEPTH 4
`define EPE_FIFO_WIDTH 9
`endif

// ---- src/epe_fifo.v ----
// small first-in first-out buffer with valid/ready on both sides
`timescale 1ns/10ps
module epe_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clock,
  input wire reset_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage words
  reg [AW-1:0] wr_ptr; // next write slot
  reg [AW-1:0] rd_ptr; // next read slot
  reg [AW:0] count; // words held
  reg out_full; // output register holds a word
  wire do_wr;
  wire do_rd;
  wire load_out;
  assign in_ready = (count != DEPTH[AW:0]);
  assign do_wr = in_valid & in_ready;
  assign load_out = (count != {(AW+1){1'b0}}) & (~out_full | out_ready);
  assign do_rd = load_out;
  assign out_valid = out_full;
  // pointer, count and output register; read data comes out of a register
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      out_full <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
        out_data <= mem[rd_ptr];
        out_full <= 1'b1;
      end else if (out_ready) begin
        out_full <= 1'b0;
      end
      if (do_wr & ~do_rd) begin
        count <= count + 1'b1;
      end else if (~do_wr & do_rd) begin
        count <= count - 1'b1;
      end
    end
  end
  // memory write, no reset needed on storage
  always @(posedge clock) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// ---- src/epe_engine.v ----
// enhanced parallel port cycle engine: host strobes to peripheral address/data cycles
// Notes on behaviour
// - address write drives byte, strobes, holds it
// - address read latches lines at strobe release
// - data write drives byte, strobes, holds it
// - data read latches lines at strobe release
// - reset clears address and data registers
// - offsets five to seven mirror data zero
// - registers only reachable in enhanced mode
// - idle: outputs follow control register bits
// - watchdog runs from host strobe assertion
// - watchdog expiry aborts, releases host, flags
// - v1.7 write: direction low, then strobe
// - v1.7: hold ready low while wait low
// - write strobe high releases strobes first; code releases direction in the same cycle
// - v1.7 read: direction high, strobe low
// - v1.9: ready low at once, await wait
// - v1.9 write: direction low, strobe, wait high
// - v1.9 read: strobe, wait high, release
// - interrupt passes through uninverted
// - active-low peripheral reset output
// - port direction high for reads or while control direction bit set
// - control strobe bit cannot disturb active cycle; direction and init bits act in any state
// - timeout flag cleared by writing one
`timescale 1ns/10ps
`include "epe_defines.vh"
module epe_engine #(
  parameter TMO_CYCLES = `EPE_TMO_CYCLES,
  parameter FIFO_DEPTH = `EPE_FIFO_DEPTH
) (
  input wire clock,
  input wire reset_n,
  input wire host_rd_n,
  input wire host_wr_n,
  input wire [2:0] host_addr,
  input wire [7:0] host_bus_byte,
  output reg [7:0] host_rd_byte,
  output reg iochrdy,
  input wire epp_mode,
  input wire version_19,
  input wire ctrl_strobe,
  input wire ctrl_autofd,
  input wire ctrl_init,
  input wire ctrl_dir_bit,
  input wire status_wr,
  input wire [7:0] status_wr_byte,
  output reg cycle_timeout_flag,
  input wire [7:0] port_lines_in,
  output reg [7:0] port_lines_out,
  output reg port_lines_oe_n,
  output reg xfer_dir_wr_n,
  output reg data_strobe_pin_n,
  output reg addr_strobe_pin_n,
  output reg strobe_pin_n,
  output reg init_pin_n,
  input wire periph_hold_n,
  input wire periph_intr,
  output reg intr_out,
  output reg periph_reset_n,
  output reg port_dir_out,
  output reg [8:0] log_data,
  output reg log_valid,
  input wire log_ready
);
  // state codes
  localparam ST_IDLE = 3'd0;
  localparam ST_WAITLO = 3'd1;
  localparam ST_STROBE = 3'd2;
  localparam ST_WAITHI = 3'd3;
  localparam ST_HOLD = 3'd4;
  localparam ST_ABORT = 3'd5;
  localparam TW = 16;
  // pin synchronisers: first stage read only by second
  reg [2:0] rd_s2; // second stage: rd, wr, hold
  reg [2:0] wr_meta;
  reg [7:0] lines_s1, lines_s2;
  reg intr_s1, intr_s2;
  reg [2:0] addr_s1, addr_s2;
  reg [7:0] db_s1, db_s2;
  reg rd_n_q, wr_n_q, hold_n_q; // synchronised levels
  reg rd_n_d, wr_n_d; // delayed for edges
  reg [2:0] state;
  reg is_read; // current cycle is a read
  reg is_addr; // current cycle is an address cycle
  reg [7:0] epp_address_byte;
  reg [7:0] epp_data_byte0;
  reg [TW-1:0] wd_count; // watchdog counter
  reg [2:0] lat_addr; // offset of current cycle
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [8:0] fifo_out_data;
  reg fifo_push;
  reg [8:0] fifo_push_data;
  wire rd_fall;
  wire wr_fall;
  wire host_end;
  wire wd_expire;
  wire tmo_clear;
  // offset decode shared by read and write paths
  function is_epp_ofs;
    input [2:0] ofs;
    begin
      is_epp_ofs = (ofs == `EPE_OFS_ADDR) | (ofs == `EPE_OFS_DATA0) |
        (ofs == `EPE_OFS_DATA1) | (ofs == `EPE_OFS_DATA2) | (ofs == `EPE_OFS_DATA3);
    end
  endfunction
  // two-flop synchronisers for every pin
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_meta <= 3'h7;
      rd_s2 <= 3'h7;
      lines_s1 <= 8'h00;
      lines_s2 <= 8'h00;
      intr_s1 <= 1'b0;
      intr_s2 <= 1'b0;
      addr_s1 <= 3'h0;
      addr_s2 <= 3'h0;
      db_s1 <= 8'h00;
      db_s2 <= 8'h00;
      rd_n_d <= 1'b1;
      wr_n_d <= 1'b1;
    end else begin
      wr_meta <= {host_rd_n, host_wr_n, periph_hold_n};
      rd_s2 <= wr_meta;
      lines_s1 <= port_lines_in;
      lines_s2 <= lines_s1;
      intr_s1 <= periph_intr;
      intr_s2 <= intr_s1;
      addr_s1 <= host_addr;
      addr_s2 <= addr_s1;
      db_s1 <= host_bus_byte;
      db_s2 <= db_s1;
      rd_n_d <= rd_s2[2];
      wr_n_d <= rd_s2[1];
    end
  end
  always @* begin
    rd_n_q = rd_s2[2];
    wr_n_q = rd_s2[1];
    hold_n_q = rd_s2[0];
  end
  assign rd_fall = rd_n_d & ~rd_n_q;
  assign wr_fall = wr_n_d & ~wr_n_q;
  assign host_end = is_read ? rd_n_q : wr_n_q;
  assign wd_expire = (wd_count >= TMO_CYCLES[TW-1:0]);
  assign tmo_clear = status_wr & status_wr_byte[`EPE_TMO_BIT];
  // cycle sequencer
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      is_read <= 1'b0;
      is_addr <= 1'b0;
      lat_addr <= 3'h0;
      epp_address_byte <= `EPE_BYTE_RESET;
      epp_data_byte0 <= `EPE_BYTE_RESET;
      wd_count <= {TW{1'b0}};
      cycle_timeout_flag <= 1'b0;
      host_rd_byte <= 8'h00;
      iochrdy <= 1'b1;
      xfer_dir_wr_n <= 1'b1;
      data_strobe_pin_n <= 1'b1;
      addr_strobe_pin_n <= 1'b1;
      port_lines_out <= 8'h00;
      fifo_push <= 1'b0;
      fifo_push_data <= 9'h000;
    end else begin
      fifo_push <= 1'b0;
      // watchdog from host strobe until wait rises
      if (state == ST_IDLE) begin
        wd_count <= {TW{1'b0}};
      end else if (state != ST_HOLD && state != ST_ABORT) begin
        wd_count <= wd_count + 1'b1;
      end
      // set wins over software clear
      if (state != ST_IDLE && state != ST_HOLD && state != ST_ABORT && wd_expire) begin
        cycle_timeout_flag <= 1'b1;
      end else if (tmo_clear) begin
        cycle_timeout_flag <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          // accesses only honoured in enhanced mode
          if (epp_mode && is_epp_ofs(addr_s2) && (rd_fall || wr_fall)) begin
            is_read <= rd_fall;
            is_addr <= (addr_s2 == `EPE_OFS_ADDR);
            lat_addr <= addr_s2;
            if (wr_fall) begin
              port_lines_out <= db_s2;
              if (addr_s2 == `EPE_OFS_ADDR) begin
                epp_address_byte <= db_s2;
              end else begin
                epp_data_byte0 <= db_s2;
              end
            end
            if (version_19) begin
              iochrdy <= 1'b0;
              state <= ST_WAITLO;
            end else begin
              // v1.7: direction first, strobe in next state
              xfer_dir_wr_n <= rd_fall;
              state <= ST_STROBE;
            end
          end
        end
        ST_WAITLO: begin
          if (wd_expire) begin
            state <= ST_ABORT;
          end else if (!hold_n_q) begin
            xfer_dir_wr_n <= is_read;
            state <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          // strobe one cycle after direction settles
          if (is_addr) begin
            addr_strobe_pin_n <= 1'b0;
          end else begin
            data_strobe_pin_n <= 1'b0;
          end
          if (!version_19) begin
            iochrdy <= 1'b0;
          end
          state <= ST_WAITHI;
        end
        ST_WAITHI: begin
          if (wd_expire) begin
            state <= ST_ABORT;
          end else if (hold_n_q) begin
            iochrdy <= 1'b1;
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // host strobe end releases direction and strobes
          if (host_end) begin
            xfer_dir_wr_n <= 1'b1;
            addr_strobe_pin_n <= 1'b1;
            data_strobe_pin_n <= 1'b1;
            if (is_read) begin
              host_rd_byte <= lines_s2;
              if (is_addr) begin
                epp_address_byte <= lines_s2;
              end else begin
                epp_data_byte0 <= lines_s2;
              end
            end
            fifo_push <= fifo_in_ready;
            fifo_push_data <= {is_read, is_read ? lines_s2 : port_lines_out};
            state <= ST_IDLE;
          end
        end
        ST_ABORT: begin
          // abort: free host and peripheral at once
          iochrdy <= 1'b1;
          xfer_dir_wr_n <= 1'b1;
          addr_strobe_pin_n <= 1'b1;
          data_strobe_pin_n <= 1'b1;
          if (host_end) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
  // pass-through pins; control strobe bit steers only while idle, direction and init bits always
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      strobe_pin_n <= 1'b1;
      init_pin_n <= 1'b0;
      intr_out <= 1'b0;
      periph_reset_n <= 1'b0;
      port_dir_out <= 1'b0;
      port_lines_oe_n <= 1'b0;
    end else begin
      intr_out <= intr_s2;
      periph_reset_n <= ctrl_init;
      init_pin_n <= ctrl_init;
      if (state == ST_IDLE) begin
        strobe_pin_n <= ~ctrl_strobe;
      end
      // direction high only for control bit or an active read
      port_dir_out <= ctrl_dir_bit | ((state != ST_IDLE) & is_read);
      port_lines_oe_n <= ctrl_dir_bit | ((state != ST_IDLE) & is_read);
    end
  end
  // unused control input kept for autofeed path at latched offset zero
  wire unused_autofd = ctrl_autofd & (lat_addr == 3'h0);
  // cycle log buffer; engine drops entries when full
  wire [8:0] log_fifo_q;
  epe_fifo #(.WIDTH(`EPE_FIFO_WIDTH), .DEPTH(FIFO_DEPTH), .AW(2)) u_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(fifo_push_data),
    .out_valid(fifo_out_valid),
    .out_ready(log_ready | ~log_valid),
    .out_data(log_fifo_q)
  );
  assign fifo_out_data = log_fifo_q;
  // log outputs registered
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      log_valid <= 1'b0;
      log_data <= 9'h000;
    end else if (log_ready | ~log_valid) begin
      log_valid <= fifo_out_valid;
      log_data <= fifo_out_data;
    end
  end
endmodule

// ---- verification/epe_periph_model.sv ----
// far-side peripheral model answering with the wait handshake
`timescale 1ns/10ps
module epe_periph_model (
  input wire clock,
  input wire data_strobe_pin_n,
  input wire addr_strobe_pin_n,
  input wire xfer_dir_wr_n,
  input wire [7:0] port_wire,
  input wire [7:0] rd_byte,
  input wire [1:0] delay,
  input wire stall,
  output reg periph_hold_n,
  output reg [7:0] drive,
  output reg [7:0] wr_byte,
  output reg wr_addr
);
  integer cnt = 0;
  wire sel = !data_strobe_pin_n || !addr_strobe_pin_n;
  // ready (wait low) at rest
  initial periph_hold_n = 1'b0;
  initial drive = 8'h5A;
  // ack after a chosen delay, stall never acks so the watchdog must fire
  always @(posedge clock) begin
    if (sel) begin
      cnt = cnt + 1;
      if (xfer_dir_wr_n) begin
        drive <= rd_byte;
      end else begin
        wr_byte <= port_wire;
        wr_addr <= !addr_strobe_pin_n;
      end
      if (cnt > delay && !stall) periph_hold_n <= 1'b1;
    end else begin
      // bus released: a changing pattern, never the last value
      cnt = 0;
      periph_hold_n <= 1'b0;
      drive <= ~drive;
    end
  end
endmodule

// ---- verification/epe_engine_assertions.sv ----
// concurrent checks on the cycle engine ports
`timescale 1ns/10ps
module epe_engine_assertions #(
  parameter TMO_CYCLES = 200,
  parameter FIFO_DEPTH = 4
) (
  input wire clock,
  input wire reset_n,
  input wire version_19,
  input wire ctrl_strobe,
  input wire status_wr,
  input wire [7:0] status_wr_byte,
  input wire cycle_timeout_flag,
  input wire iochrdy,
  input wire [7:0] port_lines_out,
  input wire port_lines_oe_n,
  input wire xfer_dir_wr_n,
  input wire data_strobe_pin_n,
  input wire addr_strobe_pin_n,
  input wire strobe_pin_n,
  input wire periph_intr,
  input wire intr_out,
  input wire port_dir_out
);
  // slack covers the abort state and the iochrdy register after the watchdog count
  localparam int LIM = TMO_CYCLES + 8;
  wire stb = !(data_strobe_pin_n && addr_strobe_pin_n);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  AST_STB_EXCL: assert property (data_strobe_pin_n || addr_strobe_pin_n)
    else $error("both strobes low");
  AST_WR_DIR_FIRST: assert property ($rose(stb) && !port_lines_oe_n && !version_19
    |-> $past(xfer_dir_wr_n) == 1'b0) else $error("strobe before write direction");
  AST_RD_DIR: assert property (stb && xfer_dir_wr_n |-> port_dir_out)
    else $error("port direction low during read");
  AST_WR_HELD: assert property (stb && !xfer_dir_wr_n
    |=> $stable(port_lines_out)) else $error("write byte moved under strobe");
  AST_RDY_BOUND: assert property ($fell(iochrdy) |-> ##[1:LIM] iochrdy)
    else $error("host stretched past watchdog");
  AST_TMO_RELEASE: assert property ($rose(cycle_timeout_flag) |-> ##[0:2] iochrdy)
    else $error("host held after timeout");
  AST_FLAG_CLR: assert property (status_wr && status_wr_byte[0] && iochrdy
    |=> !cycle_timeout_flag) else $error("flag not cleared");
  AST_FLAG_KEEP: assert property (cycle_timeout_flag
    && !(status_wr && status_wr_byte[0]) |=> cycle_timeout_flag) else $error("flag lost");
  AST_INTR: assert property ($stable(periph_intr) [*4] |-> intr_out == periph_intr)
    else $error("interrupt not passed");
  // boolean test repeated as a whole, since a sequence cannot be an operand of &&
  AST_IDLE_STB: assert property (($stable(ctrl_strobe) && !stb) [*4]
    |-> strobe_pin_n == !ctrl_strobe) else $error("idle strobe wrong");
  cover property ($rose(cycle_timeout_flag));
  cover property (!addr_strobe_pin_n && xfer_dir_wr_n);
  cover property (!data_strobe_pin_n && !xfer_dir_wr_n && version_19);
endmodule
bind epe_engine epe_engine_assertions #(.TMO_CYCLES(TMO_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .clock(clock), .reset_n(reset_n), .version_19(version_19), .ctrl_strobe(ctrl_strobe),
  .status_wr(status_wr), .status_wr_byte(status_wr_byte), .iochrdy(iochrdy),
  .cycle_timeout_flag(cycle_timeout_flag), .port_lines_out(port_lines_out),
  .port_lines_oe_n(port_lines_oe_n), .xfer_dir_wr_n(xfer_dir_wr_n),
  .data_strobe_pin_n(data_strobe_pin_n), .addr_strobe_pin_n(addr_strobe_pin_n),
  .strobe_pin_n(strobe_pin_n), .periph_intr(periph_intr), .intr_out(intr_out),
  .port_dir_out(port_dir_out));

// ---- verification/enhanced_parallel_port_engine_tb_top.sv ----
// self-checking bench for the cycle engine
`timescale 1ns/10ps
module enhanced_parallel_port_engine_tb_top;
  logic clock = 0, reset_n = 0, host_rd_n = 1, host_wr_n = 1, epp_mode = 1, version_19 = 0;
  logic ctrl_strobe = 0, ctrl_autofd = 0, ctrl_init = 1, ctrl_dir_bit = 0, status_wr = 0;
  logic periph_intr = 0, log_ready = 1, stall = 0, log_on = 1, saw = 0;
  logic [2:0] host_addr = 0;
  logic [7:0] host_bus_byte = 0, status_wr_byte = 0, rdb = 0, wb = 0;
  logic [1:0] dly = 0;
  logic [8:0] exp_q[$];
  wire [7:0] host_rd_byte, port_lines_out, wr_byte, drive, port_wire;
  wire [8:0] log_data;
  wire iochrdy, cycle_timeout_flag, port_lines_oe_n, xfer_dir_wr_n, data_strobe_pin_n;
  wire addr_strobe_pin_n, strobe_pin_n, init_pin_n, periph_hold_n, intr_out;
  wire periph_reset_n, port_dir_out, log_valid, wr_addr;
  integer fails = 0, check_count = 0, a, v, n;
  // resolved port wire: whoever enables wins
  assign port_wire = !port_lines_oe_n ? port_lines_out : drive;
  always #25 clock = ~clock;
  epe_engine #(.TMO_CYCLES(20)) dut (.clock(clock), .reset_n(reset_n),
    .host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .host_addr(host_addr),
    .host_bus_byte(host_bus_byte), .host_rd_byte(host_rd_byte), .iochrdy(iochrdy),
    .epp_mode(epp_mode), .version_19(version_19), .ctrl_strobe(ctrl_strobe),
    .ctrl_autofd(ctrl_autofd), .ctrl_init(ctrl_init), .ctrl_dir_bit(ctrl_dir_bit),
    .status_wr(status_wr), .status_wr_byte(status_wr_byte),
    .cycle_timeout_flag(cycle_timeout_flag), .port_lines_in(port_wire),
    .port_lines_out(port_lines_out), .port_lines_oe_n(port_lines_oe_n),
    .xfer_dir_wr_n(xfer_dir_wr_n), .data_strobe_pin_n(data_strobe_pin_n),
    .addr_strobe_pin_n(addr_strobe_pin_n), .strobe_pin_n(strobe_pin_n),
    .init_pin_n(init_pin_n), .periph_hold_n(periph_hold_n), .periph_intr(periph_intr),
    .intr_out(intr_out), .periph_reset_n(periph_reset_n), .port_dir_out(port_dir_out),
    .log_data(log_data), .log_valid(log_valid), .log_ready(log_ready));
  epe_periph_model u_periph (.clock(clock), .data_strobe_pin_n(data_strobe_pin_n),
    .addr_strobe_pin_n(addr_strobe_pin_n), .xfer_dir_wr_n(xfer_dir_wr_n),
    .port_wire(port_wire), .rd_byte(rdb), .delay(dly), .stall(stall),
    .periph_hold_n(periph_hold_n), .drive(drive), .wr_byte(wr_byte), .wr_addr(wr_addr));
  task chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // one host access: hold the strobe until the strobe has run and iochrdy is high
  task host(input logic rd, input logic [2:0] ad, input logic [7:0] b);
    @(negedge clock);
    host_addr = ad;
    host_bus_byte = b;
    host_rd_n = !rd;
    host_wr_n = rd;
    n = 0;
    while (data_strobe_pin_n && addr_strobe_pin_n && n < 12) begin
      @(negedge clock);
      n = n + 1;
    end
    saw = (n < 12);
    // log path holds four fifo words plus two output registers, drops the rest
    if (saw && log_on && exp_q.size() < 6) exp_q.push_back({rd, rd ? rdb : b});
    @(negedge clock);
    while (iochrdy !== 1'b1 && n < 80) begin
      @(negedge clock);
      n = n + 1;
    end
    // a host left stretched counts as a mismatch
    if (n >= 80) chk("iochrdy release", 9'h000, 9'h001);
    host_rd_n = 1'b1;
    host_wr_n = 1'b1;
    repeat (8) @(negedge clock);
  endtask
  task clr(input logic [7:0] b);
    status_wr_byte = b;
    status_wr = 1'b1;
    @(negedge clock);
    status_wr = 1'b0;
    @(negedge clock);
  endtask
  // compare every accepted log entry with the bench queue
  always @(posedge clock)
    if (log_valid === 1'b1 && log_ready && log_on)
      chk("log", log_data, exp_q.size() != 0 ? exp_q.pop_front() : 9'h1FF);
  initial begin
    #(4000 * 50);
    fails = fails + 1;
    give_verdict;
  end
  initial begin
    void'($urandom(32'h79E5));
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
    chk("rd_byte", host_rd_byte, 9'h000);
    chk("flag", cycle_timeout_flag, 9'h000);
    for (v = 0; v < 2; v = v + 1) begin
      version_19 = v[0];
      for (a = 3; a < 8; a = a + 1) begin
        dly = 2'($urandom);
        wb = 8'($urandom);
        host(1'b0, a[2:0], wb);
        chk("write", {wr_addr, wr_byte}, {a == 3, wb});
        rdb = 8'($urandom);
        host(1'b1, a[2:0], 8'h00);
        chk("read", host_rd_byte, rdb);
      end
      $display("cycle test version %0d done", v);
    end
    epp_mode = 1'b0;
    host(1'b0, 3'h4, 8'hA5);
    chk("off mode", saw, 9'h000);
    epp_mode = 1'b1;
    host(1'b0, 3'h2, 8'hA5);
    chk("bad offset", saw, 9'h000);
    $display("refusal test done");
    ctrl_strobe = 1'b1;
    ctrl_dir_bit = 1'b1;
    ctrl_init = 1'b0;
    periph_intr = 1'b1;
    repeat (6) @(negedge clock);
    chk("idle pins", {strobe_pin_n, init_pin_n}, 9'h000);
    chk("idle dir", {port_dir_out, periph_reset_n, intr_out}, 9'h005);
    ctrl_strobe = 1'b0;
    ctrl_dir_bit = 1'b0;
    ctrl_init = 1'b1;
    repeat (6) @(negedge clock);
    chk("idle back", {port_dir_out, periph_reset_n}, 9'h001);
    $display("idle test done");
    log_ready = 1'b0;
    // seven writes against six places: the last one must be dropped
    repeat (7) begin
      wb = 8'($urandom);
      host(1'b0, 3'h5, wb);
    end
    log_ready = 1'b1;
    repeat (10) @(negedge clock);
    chk("log left", 9'(exp_q.size()), 9'h000);
    $display("log test done");
    log_on = 1'b0;
    stall = 1'b1;
    host(1'b0, 3'h4, 8'h3C);
    stall = 1'b0;
    chk("timeout", cycle_timeout_flag, 9'h001);
    clr(8'hFE);
    chk("keep flag", cycle_timeout_flag, 9'h001);
    clr(8'h01);
    chk("clear flag", cycle_timeout_flag, 9'h000);
    $display("timeout test done");
    give_verdict;
  end
endmodule
